// *** inc/phy_port_pkg.sv ***
// Constants for the embedded PHY port control block
package phy_port_pkg;
  // Management register indices
  localparam logic [4:0] REG_CTRL = 5'h00;
  localparam logic [4:0] REG_STAT = 5'h01;
  localparam logic [4:0] REG_ID1 = 5'h02;
  localparam logic [4:0] REG_ID2 = 5'h03;
  localparam logic [4:0] REG_ADV = 5'h04;
  localparam logic [4:0] REG_LPA = 5'h05;
  localparam logic [4:0] REG_EXP = 5'h06;
  localparam logic [4:0] REG_MODE = 5'h11;
  localparam logic [4:0] REG_SPECIAL = 5'h1B;
  localparam logic [4:0] REG_ISRC = 5'h1D;
  localparam logic [4:0] REG_IMASK = 5'h1E;
  // Basic control bit positions
  localparam int CTRL_RESET = 15;
  localparam int CTRL_SPEED = 13;
  localparam int CTRL_AN = 12;
  localparam int CTRL_PWR_DOWN = 11;
  localparam int CTRL_DUPLEX = 8;
  localparam logic [15:0] CTRL_RESET_VAL = 16'h3100;
  localparam logic [15:0] ADV_RESET_VAL = 16'h01E1;
  // Status and mode bit positions
  localparam int STAT_AN_DONE = 5;
  localparam int STAT_LINK = 2;
  localparam int MODE_EDPD = 13;
  localparam int MODE_ENERGY = 1;
  localparam int SPC_OVERRIDE = 15;
  localparam int SPC_AUTO_EN = 14;
  localparam int SPC_STATE = 13;
  // Interrupt bit positions
  localparam int INT_ENERGY = 7;
  localparam int INT_AN_DONE = 6;
  localparam int INT_RFAULT = 5;
  localparam int INT_LINK_DOWN = 4;
  localparam int INT_LP_ACK = 3;
  localparam int INT_PD_FAULT = 2;
  localparam int INT_PAGE_RX = 1;
  localparam logic [15:0] INT_USED = 16'h00FE;
  localparam logic [15:0] UNMAPPED_VAL = 16'hFFFF;
  // Management frame fields
  localparam logic [1:0] OP_READ = 2'b10;
  localparam logic [1:0] OP_WRITE = 2'b01;
  localparam logic [2:0] FRAME_START = 3'b101;
  localparam logic [4:0] BIT_HDR_LAST = 5'd11;
  localparam logic [4:0] BIT_TA_LOW = 5'd12;
  localparam logic [4:0] BIT_LAST = 5'd29;
  // Timing
  localparam int CLK_MHZ = 25;
  localparam int PHY_RESET_US = 102;
  localparam int PHY_RESET_CYCLES = PHY_RESET_US * CLK_MHZ;
  localparam int RST_CNT_W = 12;
  typedef enum logic [1:0] {ED_ACTIVE = 2'b00, ED_SLEEP = 2'b01, ED_WAKE = 2'b11} ed_state_t;
endpackage

// *** rtl/phy_port_control.sv ***
// Control, management and MII path of one embedded 10/100 PHY port
`timescale 1ns/100ps
module phy_port_control #(
  parameter logic [4:0] PHY_ADDR = 5'h01,
  parameter logic [15:0] ID_HIGH = 16'h1234,
  parameter logic [15:0] ID_LOW = 16'h5670
) (
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  // Straps and chip reset control
  input wire logic AUTO_MDIX_STRAP,
  input wire logic MANUAL_MDIX_STRAP,
  input wire logic RELOAD_CMD,
  input wire logic DIGITAL_RESET,
  input wire logic PORT_SOFT_RESET,
  output logic PORT_SOFT_RESET_BIT,
  // Management port
  input wire logic MDC,
  input wire logic MDIO_IN,
  output logic MDIO_OUT,
  output logic MDIO_OE_N,
  // Line side status
  input wire logic LINE_ENERGY,
  input wire logic LINK_UP,
  input wire logic AN_COMPLETE,
  input wire logic AN_SPEED_100,
  input wire logic AN_FULL_DUPLEX,
  input wire logic REMOTE_FAULT,
  input wire logic LP_ACK,
  input wire logic PD_FAULT,
  input wire logic PAGE_RX,
  input wire logic [15:0] LP_ABILITY,
  // Line side data
  input wire logic LINE_RX_DV,
  input wire logic [3:0] LINE_RXD,
  output logic LINE_TXEN,
  output logic [3:0] LINE_TXD,
  // MII toward the switch MAC
  input wire logic TXEN,
  input wire logic [3:0] TXD,
  output logic RX_DV,
  output logic [3:0] RXD,
  output logic CRS,
  output logic COL,
  output logic RX_CLK_RECOVERED,
  // Port status
  output logic SPEED_100,
  output logic FULL_DUPLEX,
  output logic MDIX_AUTO,
  output logic MDIX_CROSSED,
  output logic POWERED_DOWN,
  output logic PHY_IN_RESET,
  output logic PHY_EVENT
);
  import phy_port_pkg::*;

  logic [15:0] ctrl, adv, imask, flags, rd_data, sh, wdata;
  logic edpd, spc_override, spc_auto, spc_state, strap_auto, strap_manual, strap_load;
  logic [RST_CNT_W-1:0] rst_cnt, rst_age;
  logic soft_bit, pd_q, energy_q, link_q, evt_q;
  logic [4:1] lvl_q;
  ed_state_t ed_state;
  logic mdc_q, busy, rd_hit, wr_commit, isrc_read;
  logic [2:0] pre;
  logic [4:0] cnt;
  logic [11:0] hdr, hdr_next;
  logic [15:0] ev;
  logic reset_req, active, full;

  // Strap capture after hardware reset or reload only
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      strap_load <= 1'b1;
    end else begin
      strap_load <= RELOAD_CMD;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      strap_auto <= 1'b0;
      strap_manual <= 1'b0;
    end else if (strap_load) begin
      strap_auto <= AUTO_MDIX_STRAP;
      strap_manual <= MANUAL_MDIX_STRAP;
    end
  end

  // Management frame receiver, sampled on MDC rising edges
  assign hdr_next = {hdr[10:0], MDIO_IN};
  assign wdata = {sh[14:0], MDIO_IN};
  assign wr_commit = busy && !mdc_q && MDC && cnt == BIT_LAST && hdr[11:10] == OP_WRITE && hdr[9:5] == PHY_ADDR;
  assign isrc_read = busy && !mdc_q && MDC && cnt == BIT_HDR_LAST && hdr_next[11:10] == OP_READ
    && hdr_next[9:5] == PHY_ADDR && hdr_next[4:0] == REG_ISRC;

  always_comb begin
    case (hdr_next[4:0])
      REG_CTRL: rd_data = ctrl;
      REG_STAT: rd_data = {10'h3E0, AN_COMPLETE, 2'h0, LINK_UP, 2'h1};
      REG_ID1: rd_data = ID_HIGH;
      REG_ID2: rd_data = ID_LOW;
      REG_ADV: rd_data = adv;
      REG_LPA: rd_data = LP_ABILITY;
      REG_EXP: rd_data = {11'h0, PD_FAULT, 3'h0, PAGE_RX};
      REG_MODE: rd_data = {2'h0, edpd, 11'h0, energy_q, 1'b0};
      REG_SPECIAL: rd_data = {spc_override, spc_auto, spc_state, 13'h0};
      REG_ISRC: rd_data = flags;
      REG_IMASK: rd_data = imask;
      default: rd_data = UNMAPPED_VAL;
    endcase
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      mdc_q <= 1'b0;
      busy <= 1'b0;
      pre <= 3'h0;
      cnt <= 5'h0;
      hdr <= 12'h0;
      sh <= 16'h0;
      rd_hit <= 1'b0;
      MDIO_OUT <= 1'b1;
      MDIO_OE_N <= 1'b1;
    end else begin
      mdc_q <= MDC;
      if (MDC && !mdc_q) begin
        if (!busy) begin
          pre <= {pre[1:0], MDIO_IN};
          if ({pre[1:0], MDIO_IN} == FRAME_START) begin
            busy <= 1'b1;
            cnt <= 5'h0;
          end
        end else begin
          cnt <= cnt + 5'h1;
          if (cnt <= BIT_HDR_LAST) begin
            hdr <= hdr_next;
          end
          if (cnt == BIT_HDR_LAST) begin
            rd_hit <= hdr_next[11:10] == OP_READ && hdr_next[9:5] == PHY_ADDR;
            sh <= rd_data;
          end else if (cnt == BIT_TA_LOW && rd_hit) begin
            MDIO_OUT <= 1'b0;
            MDIO_OE_N <= 1'b0;
          end else if (cnt > BIT_TA_LOW && cnt < BIT_LAST && rd_hit) begin
            MDIO_OUT <= sh[15];
            sh <= {sh[14:0], 1'b0};
          end else if (cnt > BIT_TA_LOW) begin
            sh <= wdata;
          end
          if (cnt == BIT_LAST) begin
            busy <= 1'b0;
            pre <= 3'h0;
            rd_hit <= 1'b0;
            MDIO_OUT <= 1'b1;
            MDIO_OE_N <= 1'b1;
          end
        end
      end
    end
  end

  // Writable registers; power-down never touches them, the end of a PHY reset clears only the control reset bit
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ctrl <= CTRL_RESET_VAL;
      adv <= ADV_RESET_VAL;
      imask <= 16'h0000;
      edpd <= 1'b0;
      spc_override <= 1'b0;
      spc_auto <= 1'b0;
      spc_state <= 1'b0;
    end else if (wr_commit) begin
      case (hdr[4:0])
        REG_CTRL: ctrl <= wdata;
        REG_ADV: adv <= wdata;
        REG_MODE: edpd <= wdata[MODE_EDPD];
        REG_SPECIAL: {spc_override, spc_auto, spc_state} <= wdata[SPC_OVERRIDE:SPC_STATE];
        REG_IMASK: imask <= wdata & INT_USED;
        default: ctrl <= ctrl;
      endcase
    end else if (rst_cnt == RST_CNT_W'(1)) begin
      ctrl[CTRL_RESET] <= 1'b0;
    end
  end

  // Energy-detect sleep state machine
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      ed_state <= ED_ACTIVE;
    end else begin
      case (ed_state)
        ED_ACTIVE: if (edpd && !energy_q && rst_cnt == '0) ed_state <= ED_SLEEP;
        ED_SLEEP: if (energy_q || !edpd) ed_state <= ED_WAKE;
        ED_WAKE: if (rst_cnt == RST_CNT_W'(1)) ed_state <= ED_ACTIVE;
        default: ed_state <= ED_ACTIVE;
      endcase
    end
  end

  // PHY internal reset timer; chip digital reset has no path here
  assign reset_req = (wr_commit && hdr[4:0] == REG_CTRL && wdata[CTRL_RESET]) || PORT_SOFT_RESET
    || (pd_q && !ctrl[CTRL_PWR_DOWN]) || (ed_state == ED_SLEEP && (energy_q || !edpd));

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rst_cnt <= '0;
      soft_bit <= 1'b0;
      pd_q <= 1'b0;
    end else begin
      pd_q <= ctrl[CTRL_PWR_DOWN];
      if (reset_req) begin
        rst_cnt <= RST_CNT_W'(PHY_RESET_CYCLES);
      end else if (rst_cnt != '0) begin
        rst_cnt <= rst_cnt - RST_CNT_W'(1);
      end
      if (PORT_SOFT_RESET) begin
        soft_bit <= 1'b1;
      end else if (rst_cnt == RST_CNT_W'(1)) begin
        soft_bit <= 1'b0;
      end
    end
  end

  // Interrupt events; a new event wins over the read clear
  always_comb begin
    ev = 16'h0000;
    ev[INT_ENERGY] = ed_state == ED_SLEEP && energy_q;
    ev[INT_AN_DONE] = AN_COMPLETE && !lvl_q[4];
    ev[INT_RFAULT] = REMOTE_FAULT && !lvl_q[3];
    ev[INT_LINK_DOWN] = !LINK_UP && link_q;
    ev[INT_LP_ACK] = LP_ACK && !lvl_q[2];
    ev[INT_PD_FAULT] = PD_FAULT && !lvl_q[1];
    ev[INT_PAGE_RX] = PAGE_RX && !evt_q;
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      flags <= 16'h0000;
      lvl_q <= 4'h0;
      link_q <= 1'b0;
      evt_q <= 1'b0;
      energy_q <= 1'b0;
      PHY_EVENT <= 1'b0;
    end else begin
      lvl_q <= {AN_COMPLETE, REMOTE_FAULT, LP_ACK, PD_FAULT};
      link_q <= LINK_UP;
      evt_q <= PAGE_RX;
      energy_q <= LINE_ENERGY;
      flags <= (isrc_read ? 16'h0000 : flags) | ev;
      PHY_EVENT <= |(((isrc_read ? 16'h0000 : flags) | ev) & imask);
    end
  end

  // Operating mode, crossover and MII data path
  assign active = ed_state == ED_ACTIVE && !ctrl[CTRL_PWR_DOWN] && rst_cnt == '0;
  assign full = ctrl[CTRL_AN] ? AN_FULL_DUPLEX : ctrl[CTRL_DUPLEX];

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      SPEED_100 <= 1'b0;
      FULL_DUPLEX <= 1'b0;
      MDIX_AUTO <= 1'b0;
      MDIX_CROSSED <= 1'b0;
      POWERED_DOWN <= 1'b0;
      PHY_IN_RESET <= 1'b0;
      PORT_SOFT_RESET_BIT <= 1'b0;
    end else begin
      SPEED_100 <= ctrl[CTRL_AN] ? AN_SPEED_100 : ctrl[CTRL_SPEED];
      FULL_DUPLEX <= full;
      MDIX_AUTO <= spc_override ? spc_auto : strap_auto;
      MDIX_CROSSED <= spc_override ? spc_state : (!strap_auto && strap_manual);
      POWERED_DOWN <= ctrl[CTRL_PWR_DOWN] || ed_state == ED_SLEEP;
      PHY_IN_RESET <= rst_cnt != '0;
      PORT_SOFT_RESET_BIT <= soft_bit;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      LINE_TXEN <= 1'b0;
      LINE_TXD <= 4'h0;
      RX_DV <= 1'b0;
      RXD <= 4'h0;
      CRS <= 1'b0;
      COL <= 1'b0;
      RX_CLK_RECOVERED <= 1'b0;
    end else begin
      LINE_TXEN <= TXEN && active;
      LINE_TXD <= active ? TXD : 4'h0;
      RX_DV <= LINE_RX_DV && active;
      RXD <= active ? LINE_RXD : 4'h0;
      CRS <= active && (LINE_RX_DV || (!full && TXEN));
      COL <= active && !full && LINE_RX_DV && TXEN;
      RX_CLK_RECOVERED <= active && energy_q;
    end
  end

  // Cycles since the last PHY reset request, held at the full reset length
  always_ff @(posedge SYS_CLK) begin
    if (SYS_RST) begin
      rst_age <= RST_CNT_W'(PHY_RESET_CYCLES);
    end else if (reset_req) begin
      rst_age <= '0;
    end else if (rst_age < RST_CNT_W'(PHY_RESET_CYCLES)) begin
      rst_age <= rst_age + RST_CNT_W'(1);
    end
  end

  sequence wake_seen;
    ed_state == ED_SLEEP && energy_q;
  endsequence
  sequence wake_done;
    ed_state == ED_WAKE && flags[INT_ENERGY];
  endsequence

  forced_mode_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) !ctrl[CTRL_AN] |=> SPEED_100 == $past(ctrl[CTRL_SPEED]) && FULL_DUPLEX == $past(ctrl[CTRL_DUPLEX])) else $error("forced mode not applied");
  half_col_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) active && !full && LINE_RX_DV && TXEN |=> COL && CRS) else $error("half duplex collision missed");
  full_nocol_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) full |=> !COL && (CRS == $past(active && LINE_RX_DV))) else $error("full duplex carrier wrong");
  mdix_override_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) spc_override |=> MDIX_AUTO == $past(spc_auto) && MDIX_CROSSED == $past(spc_state)) else $error("crossover override ignored");
  isrc_clear_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) isrc_read && ev == 16'h0000 |=> flags == 16'h0000 && !PHY_EVENT) else $error("flag read did not clear");
  energy_wake_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) wake_seen |=> wake_done) else $error("energy wake sequence wrong");
  wake_bound_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) ed_state == ED_WAKE |-> rst_age < RST_CNT_W'(PHY_RESET_CYCLES)) else $error("wake reset too long");
  no_sleep_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) !edpd && ed_state != ED_SLEEP |=> ed_state != ED_SLEEP) else $error("sleep entered while disabled");
  soft_set_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) PORT_SOFT_RESET |=> soft_bit && rst_age == '0) else $error("soft reset bit not set");
  soft_clear_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) soft_bit |-> rst_age < RST_CNT_W'(PHY_RESET_CYCLES)) else $error("soft reset bit timing wrong");
  pd_quiet_a: assert property (@(posedge SYS_CLK) disable iff (SYS_RST) POWERED_DOWN |-> !LINE_TXEN || $past(active)) else $error("transmit while powered down");
endmodule

// *** tb/mgmt_host.sv ***
// Management host model driving serial management frames into the port
`timescale 1ns/100ps
module mgmt_host #(
  parameter logic [4:0] PHY_ADDR = 5'h01
) (
  // Clock
  input wire logic SYS_CLK,
  // Serial management lines, data driven high by the host when released
  output logic MDC,
  output logic MDIO_DRV,
  input wire logic MDIO_WIRE
);
  import phy_port_pkg::*;
  initial begin
    MDC = 1'b0;
    MDIO_DRV = 1'b1;
  end
  // Preamble, start, opcode, address, register, turnaround, data; clock still between frames
  task automatic xfer(input logic rd, input logic [4:0] ra, input logic [15:0] wd, output logic [15:0] rv);
    logic [35:0] seq;
    seq = {4'hF, 2'b01, rd ? OP_READ : OP_WRITE, PHY_ADDR, ra, rd ? 2'b11 : 2'b10, rd ? 16'hFFFF : wd};
    rv = 16'h0000;
    for (int i = 35; i >= 0; i--) begin
      MDIO_DRV = seq[i];
      repeat (4) @(negedge SYS_CLK);
      if (i < 16) rv[i] = MDIO_WIRE;
      MDC = 1'b1;
      repeat (4) @(negedge SYS_CLK);
      MDC = 1'b0;
    end
    MDIO_DRV = 1'b1;
    @(negedge SYS_CLK);
  endtask
endmodule

// *** tb/phy_port_control_tb.sv ***
// Self-checking bench for the PHY port control block
`timescale 1ns/100ps
module phy_port_control_tb;
  import phy_port_pkg::*;
  logic SYS_CLK = 1'b0, SYS_RST = 1'b1, LINE_ENERGY = 1'b1, LINE_RX_DV = 1'b0, TXEN = 1'b0;
  logic AUTO_MDIX_STRAP = 1'b0, MANUAL_MDIX_STRAP = 1'b0, RELOAD_CMD = 1'b0, DIGITAL_RESET = 1'b0;
  logic PORT_SOFT_RESET = 1'b0, AN_SPEED_100 = 1'b1, AN_FULL_DUPLEX = 1'b1;
  logic [6:1] src = 6'h00;
  logic [15:0] LP_ABILITY = 16'h0000;
  logic [3:0] LINE_RXD = 4'h0, TXD = 4'h0, LINE_TXD, RXD;
  logic MDC, MDIO_DRV, MDIO_OUT, MDIO_OE_N, PORT_SOFT_RESET_BIT, LINE_TXEN, RX_DV, CRS, COL;
  logic SPEED_100, FULL_DUPLEX, MDIX_AUTO, MDIX_CROSSED, POWERED_DOWN, PHY_IN_RESET, PHY_EVENT, RX_CLK_RECOVERED;
  logic [15:0] rv, m;
  int n_fail = 0, checks = 0, cyc = 0, k;
  wire mdio_wire = MDIO_OE_N ? MDIO_DRV : MDIO_OUT;
  always #20 SYS_CLK = ~SYS_CLK;
  phy_port_control phy_port_control_inst (.SYS_CLK(SYS_CLK), .SYS_RST(SYS_RST),
    .AUTO_MDIX_STRAP(AUTO_MDIX_STRAP), .MANUAL_MDIX_STRAP(MANUAL_MDIX_STRAP), .RELOAD_CMD(RELOAD_CMD),
    .DIGITAL_RESET(DIGITAL_RESET), .PORT_SOFT_RESET(PORT_SOFT_RESET), .PORT_SOFT_RESET_BIT(PORT_SOFT_RESET_BIT),
    .MDC(MDC), .MDIO_IN(mdio_wire), .MDIO_OUT(MDIO_OUT), .MDIO_OE_N(MDIO_OE_N), .LINE_ENERGY(LINE_ENERGY),
    .LINK_UP(~src[4]), .AN_COMPLETE(src[6]), .AN_SPEED_100(AN_SPEED_100), .AN_FULL_DUPLEX(AN_FULL_DUPLEX),
    .REMOTE_FAULT(src[5]), .LP_ACK(src[3]), .PD_FAULT(src[2]), .PAGE_RX(src[1]), .LP_ABILITY(LP_ABILITY),
    .LINE_RX_DV(LINE_RX_DV), .LINE_RXD(LINE_RXD), .LINE_TXEN(LINE_TXEN), .LINE_TXD(LINE_TXD), .TXEN(TXEN),
    .TXD(TXD), .RX_DV(RX_DV), .RXD(RXD), .CRS(CRS), .COL(COL), .RX_CLK_RECOVERED(RX_CLK_RECOVERED),
    .FULL_DUPLEX(FULL_DUPLEX), .MDIX_AUTO(MDIX_AUTO), .MDIX_CROSSED(MDIX_CROSSED), .POWERED_DOWN(POWERED_DOWN),
    .SPEED_100(SPEED_100), .PHY_IN_RESET(PHY_IN_RESET), .PHY_EVENT(PHY_EVENT));
  mgmt_host mgmt_host_inst (.SYS_CLK(SYS_CLK), .MDC(MDC), .MDIO_DRV(MDIO_DRV), .MDIO_WIRE(mdio_wire));
  function automatic logic [15:0] ctrl_word(logic spd, logic an, logic pd, logic dup);
    return {2'b00, spd, an, pd, 2'b00, dup, 8'h00};
  endfunction
  function automatic logic crs_exp(logic full, logic tx, logic rx);
    return rx | (~full & tx);
  endfunction
  function automatic logic col_exp(logic full, logic tx, logic rx);
    return ~full & tx & rx;
  endfunction
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cy(input int n);
    repeat (n) @(negedge SYS_CLK);
  endtask
  task automatic rd(input logic [4:0] a);
    mgmt_host_inst.xfer(1'b1, a, 16'h0000, rv);
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    mgmt_host_inst.xfer(1'b0, a, d, rv);
    cy(3);
  endtask
  task automatic wait_rst;
    k = 0;
    while (PHY_IN_RESET === 1'b1 && k < 3000) begin
      cy(1);
      k++;
    end
    chk("reset ends", 0, PHY_IN_RESET);
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      print_verdict;
    end
  end
  initial begin
    k = $urandom(32'h79C9);
    LP_ABILITY = 16'($urandom);
    cy(20);
    SYS_RST = 1'b0;
    cy(3);
    rd(REG_CTRL);
    chk("ctrl reset", CTRL_RESET_VAL, rv);
    rd(REG_ADV);
    chk("adv reset", ADV_RESET_VAL, rv);
    rd(REG_LPA);
    chk("partner ability", LP_ABILITY, rv);
    for (int i = 0; i < 3; i++) begin
      rd(i == 0 ? 5'h07 + 5'($urandom_range(0, 8)) : (i == 1 ? 5'h12 : 5'h1F));
      chk("unmapped", UNMAPPED_VAL, rv);
    end
    for (int i = 0; i < 4; i++) begin
      wr(REG_CTRL, ctrl_word(i[1], 1'b0, 1'b0, i[0]));
      chk("speed", i[1], SPEED_100);
      chk("duplex", i[0], FULL_DUPLEX);
    end
    wr(REG_CTRL, ctrl_word(1'b0, 1'b1, 1'b0, 1'b0));
    chk("an speed", 1, SPEED_100 & FULL_DUPLEX);
    for (int i = 0; i < 8; i++) begin
      if (i % 4 == 0) wr(REG_CTRL, ctrl_word(1'b1, 1'b0, 1'b0, i[2]));
      TXEN = i[0];
      LINE_RX_DV = i[1];
      TXD = 4'($urandom);
      LINE_RXD = 4'($urandom);
      cy(2);
      chk("crs", crs_exp(i[2], i[0], i[1]), CRS);
      chk("col", col_exp(i[2], i[0], i[1]), COL);
      chk("tx path", {TXEN, TXD}, {LINE_TXEN, LINE_TXD});
      chk("rx path", {LINE_RX_DV, LINE_RXD}, {RX_DV, RXD});
      chk("rx clock", 1, RX_CLK_RECOVERED);
    end
    TXEN = 1'b0;
    LINE_RX_DV = 1'b0;
    for (int i = 0; i < 4; i++) begin
      wr(REG_SPECIAL, {1'b1, i[1], i[0], 13'h0000});
      chk("mdix auto", i[1], MDIX_AUTO);
      chk("mdix state", i[0], MDIX_CROSSED);
    end
    wr(REG_SPECIAL, 16'h0000);
    for (int i = 0; i < 3; i++) begin
      AUTO_MDIX_STRAP = (i == 2);
      MANUAL_MDIX_STRAP = i[0];
      RELOAD_CMD = 1'b1;
      cy(1);
      RELOAD_CMD = 1'b0;
      cy(3);
      chk("strap auto", i == 2, MDIX_AUTO);
      if (i < 2) chk("strap manual", i[0], MDIX_CROSSED);
    end
    for (int b = 1; b < 7; b++) begin
      m = 16'($urandom) & INT_USED;
      m[b] = b[0];
      wr(REG_IMASK, m);
      src[b] = 1'b1;
      cy(3);
      chk("event line", m[b], PHY_EVENT);
      rd(REG_ISRC);
      chk("flags", 16'h0001 << b, rv);
      chk("event cleared", 0, PHY_EVENT);
      rd(REG_IMASK);
      chk("mask", m, rv);
      src[b] = 1'b0;
    end
    wr(REG_IMASK, 16'h0080);
    wr(REG_CTRL, ctrl_word(1'b1, 1'b1, 1'b1, 1'b1));
    chk("power down", 1, POWERED_DOWN);
    rd(REG_IMASK);
    chk("mask kept", 16'h0080, rv);
    wr(REG_CTRL, ctrl_word(1'b1, 1'b1, 1'b0, 1'b1));
    chk("pd exit reset", 1, PHY_IN_RESET);
    wait_rst;
    rd(REG_CTRL);
    chk("ctrl kept", ctrl_word(1'b1, 1'b1, 1'b0, 1'b1), rv);
    LINE_ENERGY = 1'b0;
    cy(5);
    chk("no sleep", 0, POWERED_DOWN);
    wr(REG_MODE, 16'h2000);
    TXEN = 1'b1;
    cy(2);
    chk("sleep", 1, POWERED_DOWN);
    chk("no tx", 0, LINE_TXEN);
    chk("rx clock idle", 0, RX_CLK_RECOVERED);
    rd(REG_MODE);
    chk("mode sleep", 16'h2000, rv & 16'h2002);
    LINE_ENERGY = 1'b1;
    TXEN = 1'b0;
    cy(3);
    chk("wake", 0, POWERED_DOWN);
    chk("wake event", 1, PHY_EVENT);
    rd(REG_ISRC);
    chk("wake flag", 16'h0080, rv);
    wait_rst;
    rd(REG_MODE);
    chk("energy bit", 16'h2002, rv & 16'h2002);
    DIGITAL_RESET = 1'b1;
    cy(3);
    chk("digital reset", 0, PHY_IN_RESET);
    DIGITAL_RESET = 1'b0;
    AUTO_MDIX_STRAP = 1'b0;
    PORT_SOFT_RESET = 1'b1;
    cy(1);
    PORT_SOFT_RESET = 1'b0;
    cy(1);
    chk("soft bit set", 1, PORT_SOFT_RESET_BIT & PHY_IN_RESET);
    wait_rst;
    chk("reset length", 1, k inside {[2546:2551]});
    chk("soft bit clear", 0, PORT_SOFT_RESET_BIT);
    chk("no strap reload", 1, MDIX_AUTO);
    print_verdict;
  end
endmodule
